// ===== dual_timer.sv
// Cascadable dual 8-bit interval timer with APB register access
//
// Function
// - Each counter increments once per source tick
// - Match with period raises irq, clears counter
// - Counting resumes from zero after match
// - Period writes take effect immediately, no shadow
// - Upper mode 1xx clocks upper from lower overflow
// - Cascade uses lower clock, upper run; each unit keeps its own ff
// - Units form 8-bit and cascaded 16-bit modes
`include "dual_timer_defs.svh"
`timescale 1ns/100ps
`default_nettype none

module dual_timer (
   input wire logic mclk,
   input wire logic reset,
   input wire dual_timer_pkg::apb_req_t apb_req,
   output dual_timer_pkg::apb_rsp_t apb_rsp,
   input wire logic low_freq_clk,
   input wire logic lower_pin,
   input wire logic upper_pin,
   output logic lower_irq,
   output logic upper_irq,
   output logic lower_divider_out_pin,
   output logic upper_divider_out_pin
);
   import dual_timer_pkg::*;

   // ----------------------------------------
   // Registers
   // ----------------------------------------
   ctrl_t lower_ctrl_reg_r;
   ctrl_t upper_ctrl_reg_r;
   logic [7:0] lower_period_r;
   logic [7:0] upper_period_r;
   logic [7:0] lower_duty_r;
   logic [7:0] upper_duty_r;
   logic [1:0] misc_r;
   logic [7:0] lower_cnt_r;
   logic [7:0] upper_cnt_r;
   logic lower_ff_r;
   logic upper_ff_r;
   logic [1:0] status_r;
   logic [`PRESCALE_W-1:0] presc_r;
   logic [`PRESCALE_W-1:0] presc_nxt;
   logic [1:0] lowf_sync_r;
   logic lowf_d_r;
   logic [2:0] lowf_div_r;
   logic [1:0] lpin_sync_r;
   logic [1:0] upin_sync_r;
   logic lpin_d_r;
   logic upin_d_r;

   // ----------------------------------------
   // Prescaler and tick sources
   // ----------------------------------------
   // misc_r[0]: prescaler source select, misc_r[1]: slow state
   wire prescaler_src_sel = misc_r[0];
   wire slow_run_state = misc_r[1];
   assign presc_nxt = presc_r + `PRESCALE_W'(1);
   wire lowf_fall = lowf_d_r & ~lowf_sync_r[1];
   wire [2:0] lowf_div_nxt = lowf_div_r + 3'h1;
   wire lowf_tap3 = lowf_fall & (lowf_div_r == 3'h7);
   wire lpin_fall = lpin_d_r & ~lpin_sync_r[1];
   wire upin_fall = upin_d_r & ~upin_sync_r[1];

   function automatic logic tap_hit(input logic [`PRESCALE_W-1:0] p, input int b);
      logic [`PRESCALE_W-1:0] m;
      m = {`PRESCALE_W{1'b1}} >> (`PRESCALE_W - 1 - b);
      tap_hit = &(p | ~m);
   endfunction

   function automatic logic src_tick(input logic [2:0] sel, input logic pin_fall);
      logic slowest;
      slowest = (prescaler_src_sel | slow_run_state) ? lowf_tap3 : tap_hit(presc_r, `TAP11_BIT);
      unique case (sel)
         `CLK_TAP11: src_tick = slowest;
         `CLK_TAP7: src_tick = tap_hit(presc_r, `TAP7_BIT);
         `CLK_TAP5: src_tick = tap_hit(presc_r, `TAP5_BIT);
         `CLK_TAP3: src_tick = tap_hit(presc_r, `TAP3_BIT);
         `CLK_LOWF: src_tick = lowf_fall;
         `CLK_HALF: src_tick = presc_r[0];
         `CLK_MAIN: src_tick = 1'b1;
         `CLK_PIN: src_tick = pin_fall;
      endcase
   endfunction

   // ----------------------------------------
   // Counting and cascade
   // ----------------------------------------
   wire cascade = upper_ctrl_reg_r.mode_sel[2];
   wire lower_run = cascade ? upper_ctrl_reg_r.run_bit : lower_ctrl_reg_r.run_bit;
   wire upper_run = upper_ctrl_reg_r.run_bit;
   wire lower_tick = lower_run & src_tick(lower_ctrl_reg_r.clk_sel, lpin_fall);
   wire [15:0] cnt16 = {upper_cnt_r, lower_cnt_r};
   wire [15:0] per16 = {upper_period_r, lower_period_r};
   wire [15:0] cnt16_inc = cnt16 + 16'h0001;
   wire [7:0] lower_inc = lower_cnt_r + 8'h01;
   wire [7:0] upper_inc = upper_cnt_r + 8'h01;
   wire match16 = cascade & lower_tick & (cnt16_inc == per16);
   wire lower_match = ~cascade & lower_tick & (lower_inc == lower_period_r);
   wire lower_ovf = lower_tick & (lower_cnt_r == 8'hFF);
   wire upper_tick = cascade ? lower_ovf :
      (upper_run & src_tick(upper_ctrl_reg_r.clk_sel, upin_fall));
   wire upper_match = ~cascade & upper_tick & (upper_inc == upper_period_r);
   wire lower_div_mode = ~cascade & (lower_ctrl_reg_r.mode_sel == MODE_PDO);
   wire upper_div_mode = ~cascade & (upper_ctrl_reg_r.mode_sel == MODE_PDO);

   // ----------------------------------------
   // APB decode
   // ----------------------------------------
   wire setup = apb_req.psel & ~apb_req.penable;
   wire wr = apb_req.psel & apb_req.penable & apb_req.pwrite & apb_rsp.pready;
   wire [7:0] wd = apb_req.pwdata[7:0];
   wire hit_lc = apb_req.paddr == `OFS_LOWER_CTRL;
   wire hit_uc = apb_req.paddr == `OFS_UPPER_CTRL;
   wire hit_lp = apb_req.paddr == `OFS_LOWER_PERIOD;
   wire hit_up = apb_req.paddr == `OFS_UPPER_PERIOD;
   wire hit_ld = apb_req.paddr == `OFS_LOWER_DUTY;
   wire hit_ud = apb_req.paddr == `OFS_UPPER_DUTY;
   wire hit_st = apb_req.paddr == `OFS_STATUS;
   wire hit_cn = apb_req.paddr == `OFS_COUNT;
   wire hit_mi = apb_req.paddr == `OFS_MISC;
   wire mapped = hit_lc | hit_uc | hit_lp | hit_up | hit_ld | hit_ud | hit_st | hit_cn | hit_mi;
   wire clr_st = wr & hit_st;
   wire [31:0] rd_mux =
      hit_lc ? {24'h000000, lower_ctrl_reg_r} :
      hit_uc ? {24'h000000, upper_ctrl_reg_r} :
      hit_lp ? {24'h000000, lower_period_r} :
      hit_up ? {24'h000000, upper_period_r} :
      hit_ld ? {24'h000000, lower_duty_r} :
      hit_ud ? {24'h000000, upper_duty_r} :
      hit_st ? {30'h00000000, status_r} :
      hit_cn ? {16'h0000, cnt16} :
      hit_mi ? {30'h00000000, misc_r} : 32'h00000000;
   wire lower_irq_nxt = lower_match | match16;
   wire upper_irq_nxt = upper_match | match16;
   wire [1:0] status_nxt = {status_r[1] & ~(clr_st & wd[1]) | upper_irq_nxt,
      status_r[0] & ~(clr_st & wd[0]) | lower_irq_nxt};

   // ----------------------------------------
   // APB slave, one wait-free access phase
   // ----------------------------------------
   always_ff @(posedge mclk) begin
      if (reset) begin
         apb_rsp <= '0;
      end else begin
         apb_rsp.pready <= setup;
         apb_rsp.pslverr <= setup & ~mapped;
         apb_rsp.prdata <= (setup & ~apb_req.pwrite) ? rd_mux : 32'h00000000;
      end
   end

   always_ff @(posedge mclk) begin
      if (reset) begin
         lower_ctrl_reg_r <= ctrl_t'(`CTRL_RESET);
         upper_ctrl_reg_r <= ctrl_t'(`CTRL_RESET);
         lower_period_r <= `CMP_RESET;
         upper_period_r <= `CMP_RESET;
         lower_duty_r <= `CMP_RESET;
         upper_duty_r <= `CMP_RESET;
         misc_r <= `MISC_RESET;
      end else if (wr) begin
         if (hit_lc) lower_ctrl_reg_r <= ctrl_t'(wd);
         if (hit_uc) upper_ctrl_reg_r <= ctrl_t'(wd);
         if (hit_lp) lower_period_r <= wd;
         if (hit_up) upper_period_r <= wd;
         if (hit_ld) lower_duty_r <= wd;
         if (hit_ud) upper_duty_r <= wd;
         if (hit_mi) misc_r <= wd[1:0];
      end
   end

   // ----------------------------------------
   // Synchronisers and prescaler
   // ----------------------------------------
   always_ff @(posedge mclk) begin
      if (reset) begin
         lowf_sync_r <= 2'h0;
         lpin_sync_r <= 2'h0;
         upin_sync_r <= 2'h0;
         lowf_d_r <= 1'b0;
         lpin_d_r <= 1'b0;
         upin_d_r <= 1'b0;
         presc_r <= '0;
         lowf_div_r <= 3'h0;
      end else begin
         lowf_sync_r <= {lowf_sync_r[0], low_freq_clk};
         lpin_sync_r <= {lpin_sync_r[0], lower_pin};
         upin_sync_r <= {upin_sync_r[0], upper_pin};
         lowf_d_r <= lowf_sync_r[1];
         lpin_d_r <= lpin_sync_r[1];
         upin_d_r <= upin_sync_r[1];
         presc_r <= presc_nxt;
         if (lowf_fall) lowf_div_r <= lowf_div_nxt;
      end
   end

   // ----------------------------------------
   // Counters
   // ----------------------------------------
   always_ff @(posedge mclk) begin
      if (reset) begin
         lower_cnt_r <= 8'h00;
      end else if (!lower_run) begin
         lower_cnt_r <= 8'h00;
      end else if (lower_match | match16) begin
         lower_cnt_r <= 8'h00;
      end else if (lower_tick) begin
         lower_cnt_r <= lower_cnt_r + 8'h01;
      end
   end

   always_ff @(posedge mclk) begin
      if (reset) begin
         upper_cnt_r <= 8'h00;
      end else if (!upper_run) begin
         upper_cnt_r <= 8'h00;
      end else if (upper_match | match16) begin
         upper_cnt_r <= 8'h00;
      end else if (upper_tick) begin
         upper_cnt_r <= upper_cnt_r + 8'h01;
      end
   end

   // ----------------------------------------
   // Interrupts, status and divider flip-flops
   // ----------------------------------------
   always_ff @(posedge mclk) begin
      if (reset) begin
         lower_irq <= 1'b0;
         upper_irq <= 1'b0;
         status_r <= 2'h0;
      end else begin
         lower_irq <= lower_irq_nxt;
         upper_irq <= upper_irq_nxt;
         status_r <= status_nxt;
      end
   end

   always_ff @(posedge mclk) begin
      if (reset) begin
         lower_ff_r <= 1'b0;
         upper_ff_r <= 1'b0;
         lower_divider_out_pin <= 1'b1;
         upper_divider_out_pin <= 1'b1;
      end else begin
         if (!lower_run) lower_ff_r <= lower_ctrl_reg_r.out_ff_ctrl;
         else if (lower_match & lower_div_mode) lower_ff_r <= ~lower_ff_r;
         if (!upper_run) upper_ff_r <= upper_ctrl_reg_r.out_ff_ctrl;
         else if (upper_match & upper_div_mode) upper_ff_r <= ~upper_ff_r;
         lower_divider_out_pin <= ~lower_ff_r;
         upper_divider_out_pin <= ~upper_ff_r;
      end
   end

endmodule

`default_nettype wire

// ===== dual_timer_defs.svh
// Register offsets, field positions, reset values and clock-select codes
`ifndef DUAL_TIMER_DEFS_SVH
`define DUAL_TIMER_DEFS_SVH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define OFS_LOWER_CTRL 12'h000
`define OFS_UPPER_CTRL 12'h004
`define OFS_LOWER_PERIOD 12'h008
`define OFS_UPPER_PERIOD 12'h00C
`define OFS_LOWER_DUTY 12'h010
`define OFS_UPPER_DUTY 12'h014
`define OFS_STATUS 12'h018
`define OFS_COUNT 12'h01C
`define OFS_MISC 12'h020

// ----------------------------------------
// Control register fields
// ----------------------------------------
`define CTRL_MODE_LSB 0
`define CTRL_RUN_BIT 3
`define CTRL_CLK_LSB 4
`define CTRL_FF_BIT 7
`define CTRL_RESET 8'h00
`define CMP_RESET 8'h00
`define MISC_RESET 2'h0

// ----------------------------------------
// Clock select codes
// ----------------------------------------
`define CLK_TAP11 3'h0
`define CLK_TAP7 3'h1
`define CLK_TAP5 3'h2
`define CLK_TAP3 3'h3
`define CLK_LOWF 3'h4
`define CLK_HALF 3'h5
`define CLK_MAIN 3'h6
`define CLK_PIN 3'h7

// ----------------------------------------
// Prescaler tap positions
// ----------------------------------------
`define TAP11_BIT 10
`define TAP7_BIT 6
`define TAP5_BIT 4
`define TAP3_BIT 2
`define TAP3_LOWF_BIT 2
`define PRESCALE_W 11

`endif

// ===== dual_timer_pkg.sv
// Types shared by the cascadable dual 8-bit timer
package dual_timer_pkg;

   typedef enum logic [2:0] {
      MODE_TIMER = 3'h0,
      MODE_PDO = 3'h1,
      MODE_PWM = 3'h2,
      MODE_CASC = 3'h3,
      MODE_T16 = 3'h4,
      MODE_WARM = 3'h5,
      MODE_PWM16 = 3'h6,
      MODE_PPG = 3'h7
   } mode_t;

   typedef struct packed {
      logic out_ff_ctrl;
      logic [2:0] clk_sel;
      logic run_bit;
      mode_t mode_sel;
   } ctrl_t;

   typedef struct packed {
      logic [11:0] paddr;
      logic psel;
      logic penable;
      logic pwrite;
      logic [31:0] pwdata;
   } apb_req_t;

   typedef struct packed {
      logic [31:0] prdata;
      logic pready;
      logic pslverr;
   } apb_rsp_t;

endpackage

// ===== dual_timer_properties.sv
// Port-level checks for the cascadable dual 8-bit timer
`include "dual_timer_defs.svh"
`timescale 1ns/100ps
`default_nettype none
module dual_timer_properties (
   input wire logic mclk,
   input wire logic reset,
   input wire dual_timer_pkg::apb_req_t apb_req,
   input wire dual_timer_pkg::apb_rsp_t apb_rsp,
   input wire logic lower_irq,
   input wire logic upper_irq
);
   import dual_timer_pkg::*;
   logic [7:0] ctrl_r;
   logic [7:0] per_r;
   logic up_run_r;
   wire logic wr_s = apb_req.psel && apb_req.penable && apb_req.pwrite && apb_rsp.pready;
   wire logic bad = apb_req.paddr > `OFS_MISC;
   wire logic rd = apb_rsp.pready && !apb_req.pwrite;
   wire logic idle = !ctrl_r[3] && !up_run_r;
   always_ff @(posedge mclk) begin
      if (reset) begin
         ctrl_r <= 8'h00;
         per_r <= 8'h00;
         up_run_r <= 1'b0;
      end else if (wr_s) begin
         if (apb_req.paddr == `OFS_LOWER_CTRL) ctrl_r <= apb_req.pwdata[7:0];
         if (apb_req.paddr == `OFS_LOWER_PERIOD) per_r <= apb_req.pwdata[7:0];
         if (apb_req.paddr == `OFS_UPPER_CTRL) up_run_r <= apb_req.pwdata[3];
      end
   end
   default clocking @(posedge mclk); endclocking
   default disable iff (reset);
   sequence setup_s;
      apb_req.psel && !apb_req.penable;
   endsequence
   sequence quiet_s;
      idle && $past(idle) && $past(idle, 2);
   endsequence
   ready_after_setup_a: assert property (setup_s |=> apb_rsp.pready)
      else $error("ready missing");
   ready_single_a: assert property (apb_rsp.pready |=> !apb_rsp.pready)
      else $error("ready too long");
   ready_cause_a: assert property (apb_rsp.pready |-> $past(apb_req.psel && !apb_req.penable))
      else $error("ready without setup");
   unmapped_refused_a: assert property (apb_rsp.pready && bad |->
      apb_rsp.pslverr && apb_rsp.prdata == 32'h0) else $error("unmapped not refused");
   mapped_ok_a: assert property (apb_rsp.pready && !bad |-> !apb_rsp.pslverr)
      else $error("mapped refused");
   high_bits_zero_a: assert property (apb_rsp.pready |-> apb_rsp.prdata[31:16] == 16'h0)
      else $error("high bits set");
   ctrl_readback_a: assert property (
      rd && apb_req.paddr == `OFS_LOWER_CTRL |-> apb_rsp.prdata[7:0] == ctrl_r)
      else $error("ctrl readback");
   period_readback_a: assert property (
      rd && apb_req.paddr == `OFS_LOWER_PERIOD |-> apb_rsp.prdata[7:0] == per_r)
      else $error("period readback");
   stopped_quiet_a: assert property (quiet_s |-> !lower_irq && !upper_irq)
      else $error("irq while stopped");
endmodule
bind dual_timer dual_timer_properties chk (.mclk(mclk), .reset(reset), .apb_req(apb_req),
   .apb_rsp(apb_rsp), .lower_irq(lower_irq), .upper_irq(upper_irq));
`default_nettype wire

// ===== dual_timer_test.sv
// Self-checking bench for the cascadable dual 8-bit timer
`include "dual_timer_defs.svh"
`timescale 1ns/100ps
`default_nettype none
module dual_timer_test;
   import dual_timer_pkg::*;
   logic mclk = 1'b0;
   logic reset = 1'b1;
   apb_req_t req = '0;
   apb_rsp_t rsp;
   logic lirq;
   logic uirq;
   logic [15:0] lfsr = 16'h0037;
   logic [32:0] rd_q[$];
   int gap_q[$];
   int unit = 0;
   int gap = 0;
   int miscompares = 0;
   int checked = 0;
   wire logic wirq = (unit != 0) ? uirq : lirq;
   always #2.5 mclk = ~mclk;
   dual_timer dut (.mclk(mclk), .reset(reset), .apb_req(req), .apb_rsp(rsp),
      .low_freq_clk(1'b0), .lower_pin(1'b1), .upper_pin(1'b1), .lower_irq(lirq),
      .upper_irq(uirq), .lower_divider_out_pin(), .upper_divider_out_pin());
   function automatic logic [15:0] nxt(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction
   task automatic final_report();
      $display("checked %0d miscompares %0d", checked, miscompares);
      if (miscompares == 0 && checked > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   task automatic fail(input logic [32:0] g, input logic [32:0] e);
      miscompares++;
      $display("[FAIL] t=%0t got %h exp %h", $time, g, e);
   endtask
   task automatic cmp_rd(input logic [32:0] g, input logic [32:0] e);
      checked++;
      if (g !== e) fail(g, e);
   endtask
   task automatic cmp_gap(input int g, input int e);
      checked++;
      if (g != e) fail(33'(g), 33'(e));
   endtask
   task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d);
      int n;
      @(posedge mclk);
      req <= '{a, 1'b1, 1'b0, w, d};
      @(posedge mclk);
      req.penable <= 1'b1;
      n = 0;
      do begin
         @(posedge mclk);
         n++;
      end while (rsp.pready !== 1'b1 && n < 16);
      if (rsp.pready !== 1'b1) fail(33'h0, 33'h1);
      req.psel <= 1'b0;
      req.penable <= 1'b0;
   endtask
   task automatic rd(input logic [11:0] a, input logic [32:0] e);
      rd_q.push_back(e);
      apb(a, 1'b0, 32'h0);
   endtask
   task automatic wait_irq(input int lim);
      int n;
      n = 0;
      do begin
         @(posedge mclk);
         n++;
      end while (wirq !== 1'b1 && n < lim);
      if (wirq !== 1'b1) fail(33'(n), 33'(lim));
   endtask
   task automatic run(input int u, input logic [15:0] p);
      logic [11:0] c;
      logic [7:0] on;
      c = (u != 0) ? `OFS_UPPER_CTRL : `OFS_LOWER_CTRL;
      unit = u;
      if (u == 2) begin
         apb(`OFS_LOWER_PERIOD, 1'b1, {24'h0, p[7:0]});
         apb(`OFS_UPPER_PERIOD, 1'b1, {24'h0, p[15:8]});
         apb(`OFS_LOWER_CTRL, 1'b1, {24'h0, 1'b0, `CLK_TAP3, 1'b0, MODE_CASC});
         on = {1'b0, `CLK_TAP11, 1'b1, MODE_T16};
      end else begin
         apb(u ? `OFS_UPPER_PERIOD : `OFS_LOWER_PERIOD, 1'b1, {24'h0, p[7:0]});
         on = {1'b0, `CLK_TAP3, 1'b1, MODE_TIMER};
      end
      apb(c, 1'b1, {24'h0, on});
      wait_irq(p * 8 + 64);
      @(posedge mclk);
      repeat (2) begin
         gap_q.push_back(p * 8);
         wait_irq(p * 8 + 64);
      end
      on[3] = 1'b0;
      apb(c, 1'b1, {24'h0, on});
      rd(`OFS_COUNT, 33'h0);
      rd(c, {25'h0, on});
      $display("timer unit %0d period %0d done", u, p);
   endtask
   always @(posedge mclk) begin
      if (rsp.pready === 1'b1 && !req.pwrite && rd_q.size() > 0)
         cmp_rd({rsp.pslverr, rsp.prdata}, rd_q.pop_front());
      if (wirq === 1'b1) begin
         if (gap_q.size() > 0) cmp_gap(gap, gap_q.pop_front());
         gap = 1;
      end else begin
         gap++;
      end
   end
   initial begin
      repeat (3) @(posedge mclk);
      reset <= 1'b0;
      for (int a = 0; a <= 32; a += 4) rd(a[11:0], 33'h0);
      rd(12'h024, {1'b1, 32'h0});
      apb(12'h024, 1'b1, 32'hFFFF_FFFF);
      rd(12'h024, {1'b1, 32'h0});
      $display("register test done");
      for (int u = 0; u < 2; u++) begin
         run(u, 16'h0001);
         run(u, 16'h00FF);
         lfsr = nxt(lfsr);
         run(u, {8'h00, lfsr[7:0] | 8'h01});
      end
      run(2, 16'h0102);
      final_report();
   end
   initial begin
      #400000;
      fail(33'h0, 33'h1);
      final_report();
   end
endmodule
`default_nettype wire
